// ===== pkg/sp4m_link_if.sv
// Serial link between the port and its far end
`timescale 1ns/1ns
interface sp4m_link_if;
  logic txd;
  logic dev_rxd_o;
  logic dev_rxd_oe;
  logic far_rxd_o;
  logic far_rxd_oe;
  logic rxd;
  // Resolved data wire, idle pulled high
  assign rxd = dev_rxd_oe ? dev_rxd_o : (far_rxd_oe ? far_rxd_o : 1'b1);
  modport dev (output txd, output dev_rxd_o, output dev_rxd_oe, input rxd);
  modport far (input txd, input rxd, output far_rxd_o, output far_rxd_oe);
endinterface : sp4m_link_if

// ===== pkg/sp4m_pkg.sv
// Shared constants and types of the four-mode serial port
package sp4m_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [3:0] SP4M_ADR_SCS = 4'h0;
  localparam logic [3:0] SP4M_ADR_BUF = 4'h4;
  localparam logic [3:0] SP4M_ADR_PCR = 4'h8;
  // Field positions of serial_control_status
  localparam int SCS_MODE_HI = 7;
  localparam int SCS_MODE_LO = 6;
  localparam int SCS_MPE = 5;
  localparam int SCS_REN = 4;
  localparam int SCS_TX9 = 3;
  localparam int SCS_RX9 = 2;
  localparam int SCS_TXF = 1;
  localparam int SCS_RXF = 0;
  // Field position of baud_double in power_control_reg
  localparam int PCR_BAUD_DOUBLE = 7;
  // Reset values
  localparam logic [7:0] SCS_RST = 8'h00;
  localparam logic PCR_BAUD_DOUBLE_RST = 1'b0;
  // Timing: oscillator is clk
  localparam int CLK_HZ = 25_000_000;
  localparam int MODE0_DIV = 12;
  localparam int OVS = 16;
  localparam int M2_SLOW_DIV = 64;
  localparam int M2_FAST_DIV = 32;
  localparam logic [3:0] MODE0_LAST = 4'(MODE0_DIV - 1);
  localparam logic [3:0] MODE0_HALF = 4'(MODE0_DIV / 2);
  localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
  localparam logic [3:0] OVS_MID = 4'(OVS / 2 - 1);
  localparam logic [2:0] M2_SLOW_LAST = 3'(M2_SLOW_DIV / OVS - 1);
  localparam logic [2:0] M2_FAST_LAST = 3'(M2_FAST_DIV / OVS - 1);
  // Frame lengths in bits
  localparam logic [3:0] BITS_SHIFT = 4'h8;
  localparam logic [3:0] BITS_UART8 = 4'hA;
  localparam logic [3:0] BITS_UART9 = 4'hB;
  // Port modes
  typedef enum logic [1:0] {
    SP4M_SHIFT = 2'b00,
    SP4M_UART8 = 2'b01,
    SP4M_UART9_FIX = 2'b10,
    SP4M_UART9_VAR = 2'b11
  } sp4m_mode_t;
endpackage : sp4m_pkg

// ===== rtl/sp4m_device.sv
// Four-mode serial port with Wishbone register slave
// Notes on behaviour
// [RQ1] Receiver double-buffered; unread first frame loses one
// [RQ2] Buffer write loads transmitter; read returns receiver
// [RQ3] Shift mode: data pin both ways, clock/12
// [RQ4] 8-bit mode: start, 8 data, stop
// [RQ5] 9-bit fixed mode: ninth from tx field
// [RQ6] Variable 9-bit mode framed like fixed one
// [RQ7] Buffer write starts transmission in every mode
// [RQ8] Reception start conditions per mode
// [RQ9] 9-bit filter drops frames with ninth zero
// [RQ10] 8-bit filter drops frames without valid stop
// [RQ11] Filter bit ignored in shift mode
// [RQ12] Two mode bits select one of four
// [RQ13] Receive enable gates the start of reception
// [RQ14] Shift mode leaves received ninth untouched
// [RQ15] Transmit flag timing; only software clears
// [RQ16] Receive flag timing; only software clears
// [RQ17] Fixed mode rate clock/64 or clock/32
// [RQ18] Variable rate: timer overflow over 32, doubled
// [RQ19] Timer reload formula sets variable rate outside
// [RQ20] Timer interrupt kept off by software
// [RQ21] Buffer and ninth update with receive flag
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module sp4m_device #(
  parameter int ADR_W = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_overflow,
  output sp4m_pkg::sp4m_mode_t port_mode,
  sp4m_link_if.dev link
);
  import sp4m_pkg::*;

  logic [7:0] scs;
  logic baud_double;
  logic [7:0] rx_buf;
  logic mode0;
  logic nine;
  logic bus_req;
  logic wr_en;
  logic wr_scs;
  logic wr_buf;
  logic wr_pcr;
  logic [3:0] adr;
  logic [2:0] rxd_sync;
  logic rxd_f;
  logic rxd_prev;
  logic [2:0] div_cnt;
  logic ovf_half;
  logic tick;
  logic tx_busy;
  logic [10:0] tx_frame;
  logic [3:0] tx_ph;
  logic [3:0] tx_bitn;
  logic [3:0] tx_nbits;
  logic tx_step;
  logic tx_bit_end;
  logic ti_set;
  logic rx_busy;
  logic [3:0] rx_ph;
  logic [3:0] rx_bitn;
  logic [8:0] rx_shift;
  logic rx_step;
  logic rx_start;
  logic rx_sample;
  logic rx_last;
  logic rx_accept;
  logic [7:0] rx_byte;
  logic rx_b8;
  logic ri_set;
  logic next_txd;

  // Mode decode
  assign port_mode = sp4m_mode_t'(scs[SCS_MODE_HI:SCS_MODE_LO]); // see [RQ12]
  assign mode0 = (port_mode == SP4M_SHIFT);
  assign nine = port_mode[1]; // see [RQ6]

  // Bus decode; a write acts on the edge where the master sees ack
  assign adr = 4'(wb_adr_i);
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_en = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wr_scs = wr_en & (adr == SP4M_ADR_SCS);
  assign wr_buf = wr_en & (adr == SP4M_ADR_BUF);
  assign wr_pcr = wr_en & (adr == SP4M_ADR_PCR);

  // Ack one cycle after request, dropped the next
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // Read data; buffer address returns the receive side
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req & ~wb_ack_o) begin
      case (adr)
        SP4M_ADR_SCS: wb_dat_o <= {24'h00_0000, scs};
        SP4M_ADR_BUF: wb_dat_o <= {24'h00_0000, rx_buf}; // see [RQ2]
        SP4M_ADR_PCR: wb_dat_o <= {24'h00_0000, baud_double, 7'h00};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Data pin synchroniser and filter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxd_sync <= 3'h7;
      rxd_f <= 1'b1;
      rxd_prev <= 1'b1;
    end else begin
      rxd_sync <= {rxd_sync[1:0], link.rxd};
      if (rxd_sync[1] == rxd_sync[2]) begin
        rxd_f <= rxd_sync[2];
      end
      rxd_prev <= rxd_f;
    end
  end

  // Oversampling tick, sixteen per bit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_cnt <= 3'h0;
      ovf_half <= 1'b0;
    end else begin
      if (tick | (port_mode != SP4M_UART9_FIX)) begin
        div_cnt <= 3'h0;
      end else begin
        div_cnt <= div_cnt + 3'h1;
      end
      if (timer_overflow) begin
        ovf_half <= ~ovf_half;
      end
    end
  end

  always_comb begin
    if (port_mode == SP4M_UART9_FIX) begin
      tick = (div_cnt == (baud_double ? M2_FAST_LAST : M2_SLOW_LAST)); // see [RQ17]
    end else begin
      tick = timer_overflow & (baud_double | ovf_half); // see [RQ18]
    end
  end

  // Transmit timing
  assign tx_step = mode0 | tick;
  assign tx_bit_end = tx_busy & tx_step & (tx_ph == (mode0 ? MODE0_LAST : OVS_LAST));
  assign tx_nbits = mode0 ? BITS_SHIFT : (nine ? BITS_UART9 : BITS_UART8);
  // Flag after eighth bit, or entering the stop bit
  assign ti_set = tx_bit_end &
    (tx_bitn == (mode0 ? tx_nbits - 4'h1 : tx_nbits - 4'h2)); // see [RQ15]

  // Transmit shifter, started by a buffer write
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_busy <= 1'b0;
      tx_frame <= 11'h7FF;
      tx_ph <= 4'h0;
      tx_bitn <= 4'h0;
    end else if (wr_buf) begin
      tx_busy <= 1'b1; // see [RQ7]
      tx_ph <= 4'h0;
      tx_bitn <= 4'h0;
      if (mode0) begin
        tx_frame <= {3'h7, wb_dat_i[7:0]}; // see [RQ3]
      end else begin
        tx_frame <= {1'b1, nine ? scs[SCS_TX9] : 1'b1, wb_dat_i[7:0], 1'b0}; // see [RQ4] [RQ5]
      end
    end else if (tx_busy & tx_step) begin
      if (tx_bit_end) begin
        tx_ph <= 4'h0;
        tx_frame <= {1'b1, tx_frame[10:1]};
        tx_bitn <= tx_bitn + 4'h1;
        if (tx_bitn == tx_nbits - 4'h1) begin
          tx_busy <= 1'b0;
        end
      end else begin
        tx_ph <= tx_ph + 4'h1;
      end
    end
  end

  // Receive timing and start conditions
  assign rx_step = mode0 | tick;
  assign rx_start = ~rx_busy & scs[SCS_REN] & (mode0 ?
    (~scs[SCS_RXF] & ~tx_busy & ~wr_buf) : (rxd_prev & ~rxd_f)); // see [RQ8] [RQ13]
  assign rx_sample = rx_busy & rx_step & (rx_ph == (mode0 ? MODE0_LAST : OVS_MID));
  assign rx_last = rx_sample &
    (rx_bitn == (mode0 ? BITS_SHIFT - 4'h1 : (nine ? 4'h9 : 4'h8) + 4'h1));
  assign rx_byte = mode0 ? {rxd_f, rx_shift[8:2]} : (nine ? rx_shift[7:0] : rx_shift[8:1]);
  assign rx_b8 = nine ? rx_shift[8] : rxd_f; // see [RQ4] [RQ5]

  // Frame filter; an unread frame blocks the new one
  always_comb begin
    if (mode0) begin
      rx_accept = ~scs[SCS_RXF]; // see [RQ11]
    end else if (nine) begin
      rx_accept = ~scs[SCS_RXF] & (~scs[SCS_MPE] | rx_shift[8]); // see [RQ9]
    end else begin
      rx_accept = ~scs[SCS_RXF] & (~scs[SCS_MPE] | rxd_f); // see [RQ10]
    end
  end
  assign ri_set = rx_last & rx_accept; // see [RQ16] [RQ1]

  // Receive shifter; in the UART modes runs while the buffer still holds the last byte, in shift mode starts only once the flag is clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_busy <= 1'b0;
      rx_ph <= 4'h0;
      rx_bitn <= 4'h0;
      rx_shift <= 9'h000;
    end else if (rx_start) begin
      rx_busy <= 1'b1;
      rx_ph <= 4'h0;
      rx_bitn <= 4'h0;
    end else if (rx_busy & rx_step) begin
      if (rx_sample) begin
        if (~mode0 & (rx_bitn == 4'h0) & rxd_f) begin
          rx_busy <= 1'b0; // False start bit
        end else if (rx_last) begin
          rx_busy <= 1'b0;
        end else if (mode0 | (rx_bitn != 4'h0)) begin
          rx_shift <= {rxd_f, rx_shift[8:1]}; // see [RQ1]
        end
      end
      if (rx_ph == (mode0 ? MODE0_LAST : OVS_LAST)) begin
        rx_ph <= 4'h0;
        rx_bitn <= rx_bitn + 4'h1;
      end else begin
        rx_ph <= rx_ph + 4'h1;
      end
    end
  end

  // Receive buffer, loaded only with the flag
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_buf <= 8'h00;
    end else if (ri_set) begin
      rx_buf <= rx_byte; // see [RQ21] [RQ2]
    end
  end

  // Control and status; hardware set wins over software clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scs <= SCS_RST;
    end else begin
      if (wr_scs) begin
        scs <= wb_dat_i[7:0];
      end
      if (ri_set & ~mode0) begin
        scs[SCS_RX9] <= rx_b8; // see [RQ14] [RQ21]
      end
      if (ti_set) begin
        scs[SCS_TXF] <= 1'b1; // see [RQ15]
      end
      if (ri_set) begin
        scs[SCS_RXF] <= 1'b1; // see [RQ16]
      end
    end
  end

  // Rate doubling bit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      baud_double <= PCR_BAUD_DOUBLE_RST;
    end else if (wr_pcr) begin
      baud_double <= wb_dat_i[PCR_BAUD_DOUBLE];
    end
  end

  // Output pin selection: shift clock or serial data
  always_comb begin
    if (!mode0) begin
      next_txd = tx_frame[0];
    end else if (tx_busy) begin
      next_txd = (tx_ph >= MODE0_HALF); // see [RQ3]
    end else if (rx_busy) begin
      next_txd = (rx_ph >= MODE0_HALF);
    end else begin
      next_txd = 1'b1;
    end
  end

  // Registered pin drivers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      link.txd <= 1'b1;
      link.dev_rxd_o <= 1'b1;
      link.dev_rxd_oe <= 1'b0;
    end else begin
      link.txd <= next_txd;
      link.dev_rxd_o <= tx_frame[0];
      link.dev_rxd_oe <= mode0 & tx_busy & ~wr_buf; // see [RQ3]
    end
  end
endmodule : sp4m_device

// ===== rtl/sp4m_far.sv
// Far end: UART node or external shift register
`timescale 1ns/1ns
module sp4m_far #(
  parameter int BIT_CYCLES = sp4m_pkg::M2_SLOW_DIV
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic shift_mode,
  input wire logic nine_bits,
  input wire logic tx_start,
  input wire logic [8:0] tx_data,
  output logic tx_busy,
  output logic rx_valid,
  output logic [8:0] rx_data,
  output logic rx_stop_ok,
  sp4m_link_if.far link
);
  import sp4m_pkg::*;

  logic [2:0] txd_sync;
  logic txd_f;
  logic txd_prev;
  logic clk_rise;
  logic clk_fall;
  logic armed;
  logic [7:0] sh_out;
  logic [3:0] sh_cnt;
  logic [7:0] sh_cap;
  logic [2:0] cap_cnt;
  logic [15:0] tx_cnt;
  logic [3:0] tx_bitn;
  logic [10:0] tx_frame;
  logic [15:0] rx_cnt;
  logic [3:0] rx_bitn;
  logic rx_busy;
  logic [8:0] rx_shift;
  logic [3:0] nd;

  assign nd = nine_bits ? 4'h9 : 4'h8;

  // Device output pin synchroniser and edges
  always_ff @(posedge clk) begin
    if (!nrst) begin
      txd_sync <= 3'h7;
      txd_f <= 1'b1;
      txd_prev <= 1'b1;
    end else begin
      txd_sync <= {txd_sync[1:0], link.txd};
      if (txd_sync[1] == txd_sync[2]) begin
        txd_f <= txd_sync[2];
      end
      txd_prev <= txd_f;
    end
  end
  assign clk_rise = ~txd_prev & txd_f;
  assign clk_fall = txd_prev & ~txd_f;

  // Shift register end: capture on rise, advance on fall
  always_ff @(posedge clk) begin
    if (!nrst) begin
      armed <= 1'b0;
      sh_out <= 8'hFF;
      sh_cnt <= 4'h0;
      sh_cap <= 8'h00;
      cap_cnt <= 3'h0;
    end else if (shift_mode) begin
      if (tx_start) begin
        sh_out <= tx_data[7:0];
        sh_cnt <= BITS_SHIFT;
        armed <= 1'b0;
      end else if (clk_rise) begin
        armed <= 1'b1;
        sh_cap <= {link.rxd, sh_cap[7:1]};
        cap_cnt <= cap_cnt + 3'h1;
      end else if (clk_fall & armed) begin
        armed <= 1'b0;
        sh_out <= {1'b1, sh_out[7:1]};
        if (sh_cnt != 4'h0) begin
          sh_cnt <= sh_cnt - 4'h1;
        end
      end
    end
  end

  // Asynchronous transmitter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_busy <= 1'b0;
      tx_cnt <= 16'h0000;
      tx_bitn <= 4'h0;
      tx_frame <= 11'h7FF;
    end else if (tx_start & ~shift_mode) begin
      tx_busy <= 1'b1;
      tx_cnt <= 16'h0000;
      tx_bitn <= 4'h0;
      tx_frame <= {1'b1, nine_bits ? tx_data[8] : 1'b1, tx_data[7:0], 1'b0};
    end else if (tx_busy) begin
      if (tx_cnt == 16'(BIT_CYCLES - 1)) begin
        tx_cnt <= 16'h0000;
        tx_frame <= {1'b1, tx_frame[10:1]};
        tx_bitn <= tx_bitn + 4'h1;
        if (tx_bitn == nd + 4'h1) begin
          tx_busy <= 1'b0;
        end
      end else begin
        tx_cnt <= tx_cnt + 16'h0001;
      end
    end
  end

  // Asynchronous receiver, sampling mid-bit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_busy <= 1'b0;
      rx_cnt <= 16'h0000;
      rx_bitn <= 4'h0;
      rx_shift <= 9'h000;
      rx_valid <= 1'b0;
      rx_data <= 9'h000;
      rx_stop_ok <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (shift_mode) begin
        rx_busy <= 1'b0;
        if (clk_rise & (cap_cnt == 3'h7)) begin
          rx_valid <= 1'b1;
          rx_data <= {1'b0, link.rxd, sh_cap[7:1]};
        end
      end else if (~rx_busy) begin
        if (clk_fall) begin
          rx_busy <= 1'b1;
          rx_cnt <= 16'h0000;
          rx_bitn <= 4'h0;
        end
      end else if (rx_cnt == 16'(BIT_CYCLES / 2 - 1)) begin
        rx_cnt <= rx_cnt + 16'h0001;
        if ((rx_bitn == 4'h0) & txd_f) begin
          rx_busy <= 1'b0;
        end else if (rx_bitn == nd + 4'h1) begin
          rx_busy <= 1'b0;
          rx_valid <= 1'b1;
          rx_stop_ok <= txd_f;
          rx_data <= nine_bits ? rx_shift : {1'b0, rx_shift[8:1]};
        end else if (rx_bitn != 4'h0) begin
          rx_shift <= {txd_f, rx_shift[8:1]};
        end
      end else if (rx_cnt == 16'(BIT_CYCLES - 1)) begin
        rx_cnt <= 16'h0000;
        rx_bitn <= rx_bitn + 4'h1;
      end else begin
        rx_cnt <= rx_cnt + 16'h0001;
      end
    end
  end

  // Data pin drive: async idles high, shift mode only while loaded
  assign link.far_rxd_o = shift_mode ? sh_out[0] : tx_frame[0];
  assign link.far_rxd_oe = shift_mode ? (sh_cnt != 4'h0) : 1'b1;
endmodule : sp4m_far

// ===== tb/sp4m_asserts.sv
// Link checker for the four-mode serial port
`timescale 1ns/1ns
module sp4m_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic txd,
  input wire logic dev_rxd_o,
  input wire logic dev_rxd_oe,
  input wire logic far_rxd_o,
  input wire logic far_rxd_oe,
  input wire logic rxd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Wire rules and shift clock shape
  property p_rst_idle; $rose(nrst) |-> txd && rxd && !dev_rxd_oe; endproperty
  property p_one_driver; dev_rxd_oe |-> !far_rxd_oe; endproperty
  property p_dev_wins; dev_rxd_oe |-> rxd == dev_rxd_o; endproperty
  property p_pull_up; !dev_rxd_oe && !far_rxd_oe |-> rxd; endproperty
  property p_low_min; $fell(txd) |-> !txd [*6]; endproperty
  property p_high_min; $rose(txd) |-> txd [*6]; endproperty
  property p_data_hold; dev_rxd_oe && $rose(txd) |=> $stable(dev_rxd_o) [*4]; endproperty
  property p_clk_soon; $rose(dev_rxd_oe) |-> ##[0:13] $fell(txd); endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("lines not idle after reset");
  a_one_driver: assert property (p_one_driver) else $error("both ends drive data");
  a_dev_wins: assert property (p_dev_wins) else $error("data wire level wrong");
  a_pull_up: assert property (p_pull_up) else $error("released wire not high");
  a_low_min: assert property (p_low_min) else $error("txd low too short");
  a_high_min: assert property (p_high_min) else $error("txd high too short");
  a_data_hold: assert property (p_data_hold) else $error("shift data moved");
  a_clk_soon: assert property (p_clk_soon) else $error("no shift clock");
  // Main scenarios
  c_shift_out: cover property ($rose(dev_rxd_oe));
  c_far_drive: cover property (far_rxd_oe && $fell(far_rxd_o));
  c_async_tx: cover property (!dev_rxd_oe && $fell(txd));
endmodule : sp4m_asserts

// ===== tb/tb_serial_port_four_mode.sv
// Testbench of the four-mode serial port, both ends joined
`timescale 1ns/1ns
module tb_serial_port_four_mode;
  import sp4m_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic ovf = 1'b0;
  int ovf_per = 2;
  int ovf_cnt = 0;
  sp4m_mode_t port_mode;
  logic far_start = 1'b0;
  logic [8:0] far_data = 9'h000;
  logic far_busy;
  logic far_valid;
  logic [8:0] far_rx;
  logic far_stop;
  logic [8:0] far_got = 9'h000;
  logic far_stop_got = 1'b0;
  int far_cnt = 0;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] q;
  sp4m_link_if link();
  sp4m_device sp4m_device_inst (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer_overflow(ovf), .port_mode(port_mode), .link(link)
  );
  sp4m_far #(.BIT_CYCLES(64)) sp4m_far_inst (
    .clk(clk), .nrst(nrst), .shift_mode(port_mode == SP4M_SHIFT), .nine_bits(port_mode[1]),
    .tx_start(far_start), .tx_data(far_data), .tx_busy(far_busy), .rx_valid(far_valid),
    .rx_data(far_rx), .rx_stop_ok(far_stop), .link(link)
  );
  sp4m_asserts sp4m_asserts_inst (
    .clk(clk), .nrst(nrst), .txd(link.txd), .dev_rxd_o(link.dev_rxd_o),
    .dev_rxd_oe(link.dev_rxd_oe), .far_rxd_o(link.far_rxd_o),
    .far_rxd_oe(link.far_rxd_oe), .rxd(link.rxd)
  );
  always #20 clk = ~clk;
  // Timer overflow pulse every ovf_per clocks, no timer interrupt
  always @(posedge clk) begin
    ovf_cnt <= (ovf_cnt + 1 >= ovf_per) ? 0 : ovf_cnt + 1;
    ovf <= (ovf_cnt == 0);
  end
  // Frames taken by the far end
  always @(posedge clk) begin
    if (far_valid === 1'b1) begin
      far_got <= far_rx;
      far_stop_got <= far_stop;
      far_cnt <= far_cnt + 1;
    end
  end
  task automatic stop_test;
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One classic Wishbone cycle, read data left in q
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : wb
  task automatic far_send(input logic [8:0] d);
    int n;
    n = 0;
    @(posedge clk);
    far_data <= d;
    far_start <= 1'b1;
    @(posedge clk);
    far_start <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (far_busy !== 1'b0 && n < 2000);
    if (n >= 2000) chk(32'h0, 32'h1);
  endtask : far_send
  task automatic dev_send(input logic [7:0] d);
    int c;
    int n;
    c = far_cnt;
    n = 0;
    wb(1'b1, SP4M_ADR_BUF, {24'h0, d});
    while (far_cnt == c && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) chk(32'h0, 32'h1);
  endtask : dev_send
  task automatic t_regs;
    wb(1'b0, SP4M_ADR_SCS, 32'h0);
    chk(q, {24'h0, SCS_RST});
    wb(1'b0, SP4M_ADR_PCR, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 4'hC, 32'hFF);
    wb(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, SP4M_ADR_SCS, {24'h0, 2'(m), 6'h0});
      @(posedge clk);
      chk({30'h0, port_mode}, 32'(m));
    end
  endtask : t_regs
  task automatic t_tx9;
    wb(1'b1, SP4M_ADR_SCS, 32'h88);
    dev_send(8'hA5);
    chk({23'h0, far_got}, 32'h1A5);
    wb(1'b0, SP4M_ADR_SCS, 32'h0);
    chk(q & 32'h2, 32'h2);
    wb(1'b1, SP4M_ADR_SCS, 32'hC0);
    dev_send(8'h5A);
    chk({23'h0, far_got}, 32'h05A);
  endtask : t_tx9
  task automatic t_rx9;
    wb(1'b1, SP4M_ADR_SCS, 32'hB0);
    far_send(9'h03C);
    wb(1'b0, SP4M_ADR_SCS, 32'h0);
    chk(q & 32'h5, 32'h0);
    far_send(9'h15A);
    wb(1'b0, SP4M_ADR_SCS, 32'h0);
    chk(q & 32'h5, 32'h5);
    wb(1'b0, SP4M_ADR_BUF, 32'h0);
    chk(q, 32'h5A);
    far_send(9'h1C3);
    wb(1'b0, SP4M_ADR_BUF, 32'h0);
    chk(q, 32'h5A);
  endtask : t_rx9
  task automatic t_uart8;
    ovf_per = 4;
    wb(1'b1, SP4M_ADR_PCR, 32'h80);
    wb(1'b1, SP4M_ADR_SCS, 32'h60);
    far_send(9'h055);
    wb(1'b0, SP4M_ADR_SCS, 32'h0);
    chk(q & 32'h1, 32'h0);
    wb(1'b1, SP4M_ADR_SCS, 32'h70);
    far_send(9'h081);
    wb(1'b0, SP4M_ADR_SCS, 32'h0);
    chk(q & 32'h5, 32'h5);
    wb(1'b0, SP4M_ADR_BUF, 32'h0);
    chk(q, 32'h81);
    dev_send(8'h3C);
    chk({23'h0, far_stop_got, far_got[7:0]}, 32'h13C);
  endtask : t_uart8
  task automatic t_shift;
    wb(1'b1, SP4M_ADR_SCS, 32'h04);
    dev_send(8'h96);
    chk({24'h0, far_got[7:0]}, 32'h96);
    wb(1'b0, SP4M_ADR_SCS, 32'h0);
    chk(q & 32'h2, 32'h2);
    far_send(9'h0C3);
    wb(1'b1, SP4M_ADR_SCS, 32'h14);
    for (int n = 0; n < 200 && q[0] !== 1'b1; n++) begin
      wb(1'b0, SP4M_ADR_SCS, 32'h0);
    end
    chk(q & 32'h5, 32'h5);
    wb(1'b0, SP4M_ADR_BUF, 32'h0);
    chk(q, 32'hC3);
  endtask : t_shift
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_tx9();
    t_rx9();
    t_uart8();
    t_shift();
    stop_test();
  end
  // Watchdog well beyond the expected frame traffic
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule : tb_serial_port_four_mode
